// *** include/tcc_consts.vh ***
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// Termination classes per CC line.
`define TCC_TERM_OPEN 2'h0
`define TCC_TERM_SINK 2'h1
`define TCC_TERM_CABLE 2'h2

// Current advertisement levels.
`define TCC_ADV_DEF 2'h0
`define TCC_ADV_1P5 2'h1
`define TCC_ADV_3P0 2'h2

// Connection report codes.
`define TCC_CONN_NONE 3'h0
`define TCC_CONN_SINK 3'h1
`define TCC_CONN_CABLE 3'h2
`define TCC_CONN_CABLE_SINK 3'h3
`define TCC_CONN_DEBUG 3'h4
`define TCC_CONN_AUDIO 3'h5
`define TCC_CONN_SOURCE 3'h6

// Sampled-level settling time.
`define TCC_SETTLE_NS 100
`define TCC_CLK_NS 10
`define TCC_SETTLE_CYC ((`TCC_SETTLE_NS + `TCC_CLK_NS - 1) / `TCC_CLK_NS)

// Default CC comparator thresholds, in ADC codes, per advertisement level and for fast role swap, then the 5 V current limit.
`define TCC_DET_DEF 10'h0266
`define TCC_DET_1P5 10'h0266
`define TCC_DET_3P0 10'h0333
`define TCC_CAB_DEF 10'h0033
`define TCC_CAB_1P5 10'h0066
`define TCC_CAB_3P0 10'h00CC
`define TCC_FRS_TH 10'h0080
`define TCC_ADV_SNK_1P5 10'h00C0
`define TCC_ADV_SNK_3P0 10'h0180
`define TCC_ILIM 10'h0300

`endif

// *** test/tcc_attach_detect_assertions.sv ***
`include "tcc_consts.vh"

module tcc_attach_detect_assertions #(
  parameter AW = 10
) (
  // Clock, reset and inputs.
  input wire clk,
  input wire rst_n,
  input wire [1:0] adv_sel,
  input wire tx_req,
  input wire role_source,
  input wire frs_en,
  input wire frs_req,
  input wire [AW-1:0] cc_line_a,
  input wire [AW-1:0] cc_line_b,
  input wire use_trimmed,
  input wire vbus_present,
  input wire [AW-1:0] five_volt_current,
  // Outputs.
  input wire vbus_on_q,
  input wire vconn_a_q,
  input wire vconn_b_q,
  input wire five_volt_current_limit_q,
  input wire tx_oe_a_q,
  input wire tx_oe_b_q,
  input wire [2:0] conn_state_q,
  input wire orient_b_q,
  input wire watch_a_q,
  input wire watch_b_q,
  input wire [AW-1:0] five_volt_current_q,
  input wire attach_source_current_q,
  input wire trimmed_pulldown_q,
  input wire role_swap_pulldown_a_q,
  input wire role_swap_pulldown_b_q,
  input wire fast_role_swap_q,
  input wire role_is_source_q,
  input wire untrimmed_pulldown_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire off = !vbus_on_q && !vconn_a_q && !vconn_b_q;
  wire [2:0] cs = conn_state_q;
  // Default and 1.5 A share one detach level, so only 3 A differs.
  sequence s_high_a;
    cs == `TCC_CONN_SINK && watch_a_q && cc_line_a >=
      (adv_sel == 2'h2 ? `TCC_DET_3P0 : `TCC_DET_DEF);
  endsequence
  sequence s_gone;
    cs == `TCC_CONN_NONE && !vbus_on_q;
  endsequence
  sequence s_swap_req;
    frs_en && frs_req && role_source && role_is_source_q &&
      cs == `TCC_CONN_SINK;
  endsequence
  sequence s_swap_done;
    role_swap_pulldown_a_q != role_swap_pulldown_b_q &&
      role_swap_pulldown_b_q == orient_b_q ##1
      !vbus_on_q && !attach_source_current_q;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  none_unpowered_a: assert property (cs == `TCC_CONN_NONE |-> off)
    else $error("power applied with nothing attached");
  sink_power_a: assert property (cs == `TCC_CONN_SINK |->
    vbus_on_q && !vconn_a_q && !vconn_b_q && watch_a_q != watch_b_q
    && watch_b_q == orient_b_q) else $error("sink attach outputs wrong");
  cable_off_a: assert property (cs == `TCC_CONN_CABLE |-> off)
    else $error("power applied to cable without sink");
  cable_sink_a: assert property (cs == `TCC_CONN_CABLE_SINK |->
    vbus_on_q && vconn_a_q != vconn_b_q && vconn_a_q == orient_b_q
    && watch_b_q == orient_b_q) else $error("vconn on wrong line");
  detach_a: assert property (s_high_a |=> s_gone)
    else $error("detach not registered");
  tx_single_a: assert property (tx_oe_a_q || tx_oe_b_q |->
    !(tx_oe_a_q && tx_oe_b_q) && $past(tx_req))
    else $error("driver enabled without transmit");
  sink_vbus_a: assert property (cs == `TCC_CONN_SOURCE |->
    $past(vbus_present)) else $error("sink attach without vbus");
  limit_a: assert property (five_volt_current > `TCC_ILIM |=>
    five_volt_current_limit_q) else $error("current limit not engaged");
  sense_a: assert property (1'b1 |=>
    five_volt_current_q == $past(five_volt_current))
    else $error("current reading stale");
  trim_switch_a: assert property ($fell(untrimmed_pulldown_q) |->
    $past(use_trimmed)) else $error("untrimmed released unasked");
  swap_request_a: assert property (s_swap_req |=> s_swap_done)
    else $error("swap request not carried out");
  swap_detect_a: assert property (frs_en && !role_is_source_q &&
    vbus_present && cs == `TCC_CONN_SOURCE &&
    (orient_b_q ? cc_line_b : cc_line_a) < `TCC_FRS_TH |=>
    fast_role_swap_q && role_is_source_q && cs == `TCC_CONN_NONE)
    else $error("fast role swap not taken");
  swap_flag_a: assert property ($rose(fast_role_swap_q) |->
    role_is_source_q && $past(frs_en)) else $error("swap flag unasked");
  source_role_a: assert property (role_is_source_q |->
    attach_source_current_q && !trimmed_pulldown_q)
    else $error("source terminations wrong");
  sink_trim_a: assert property (!role_is_source_q &&
    !$past(untrimmed_pulldown_q) |-> trimmed_pulldown_q)
    else $error("trimmed pulldown missing");
endmodule

bind tcc_attach_detect tcc_attach_detect_assertions #(.AW(AW)) chk_u (
  .clk, .rst_n, .adv_sel, .tx_req, .cc_line_a, .use_trimmed, .vbus_present,
  .five_volt_current, .vbus_on_q, .vconn_a_q, .vconn_b_q,
  .five_volt_current_limit_q, .tx_oe_a_q, .tx_oe_b_q, .conn_state_q,
  .orient_b_q, .watch_a_q, .watch_b_q, .five_volt_current_q,
  .role_source, .frs_en, .frs_req, .cc_line_b, .attach_source_current_q,
  .trimmed_pulldown_q, .role_swap_pulldown_a_q, .role_swap_pulldown_b_q,
  .fast_role_swap_q, .role_is_source_q,
  .untrimmed_pulldown_q
);

// *** test/tcc_partner.sv ***
`include "tcc_consts.vh"

module tcc_partner (
  // Termination per line and source behaviour.
  input wire [1:0] term_a,
  input wire [1:0] term_b,
  input wire [9:0] sink_lvl,
  input wire [9:0] cab_lvl,
  input wire src_mode,
  input wire [9:0] src_lvl,
  input wire src_vbus,
  // Levels seen by the port.
  output wire [9:0] cc_a,
  output wire [9:0] cc_b,
  output wire vbus
);
  timeunit 1ns;
  timeprecision 100ps;
  // Only DC bias is modelled; this partner never drives BMC.
  function automatic [9:0] lvl(input [1:0] t);
    lvl = t == `TCC_TERM_SINK ? sink_lvl :
      t == `TCC_TERM_CABLE ? cab_lvl : 10'h03ff;
  endfunction
  assign cc_a = src_mode ? src_lvl : lvl(term_a);
  assign cc_b = src_mode ? 10'h0000 : lvl(term_b);
  assign vbus = src_mode & src_vbus;
endmodule

// *** test/typec_cc_attach_detect_bench.sv ***
`include "tcc_consts.vh"

module typec_cc_attach_detect_bench;
  timeunit 1ns;
  timeprecision 100ps;
  reg clk = 0, rst_n = 0, role_source = 1, frs_en = 0, frs_req = 0;
  reg use_trimmed = 0, tx_req = 0, src_mode = 0, src_vbus = 0;
  reg [1:0] adv_sel = 0, term_a = 0, term_b = 0;
  reg [9:0] sink_lvl = 10'h0100, cab_lvl = 10'h0010;
  reg [9:0] src_lvl = 0, fvc = 0;
  reg [9:0] cab_t [0:2] = '{`TCC_CAB_DEF, `TCC_CAB_1P5, `TCC_CAB_3P0};
  reg [9:0] det_t [0:2] = '{`TCC_DET_DEF, `TCC_DET_1P5, `TCC_DET_3P0};
  wire [9:0] cc_a, cc_b;
  wire vbus;
  wire [2:0] conn_state_q;
  wire [1:0] partner_adv_q;
  int n_errors = 0, cmp_count = 0;
  reg [4:0] q [$];
  always #5 clk = ~clk;
  tcc_partner far_u (.term_a(term_a), .term_b(term_b), .sink_lvl(sink_lvl),
    .cab_lvl(cab_lvl), .src_mode(src_mode), .src_lvl(src_lvl),
    .src_vbus(src_vbus), .cc_a(cc_a), .cc_b(cc_b), .vbus(vbus));
  tcc_attach_detect dut_u (.clk(clk), .rst_n(rst_n),
    .role_source(role_source), .adv_sel(adv_sel), .frs_en(frs_en),
    .frs_req(frs_req), .use_trimmed(use_trimmed), .tx_req(tx_req),
    .cc_line_a(cc_a), .cc_line_b(cc_b), .vbus_present(vbus),
    .five_volt_current(fvc), .attach_source_current_q(),
    .trimmed_pulldown_q(), .untrimmed_pulldown_q(),
    .role_swap_pulldown_a_q(), .role_swap_pulldown_b_q(), .vbus_on_q(),
    .vconn_a_q(), .vconn_b_q(), .five_volt_current_limit_q(),
    .tx_oe_a_q(), .tx_oe_b_q(), .conn_state_q(conn_state_q),
    .orient_b_q(), .partner_adv_q(partner_adv_q), .fast_role_swap_q(),
    .role_is_source_q(), .watch_a_q(), .watch_b_q(),
    .five_volt_current_q());
  //////////////////////////////////////////////////////////////////////
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input [2:0] e, input [2:0] g);
    cmp_count++;
    if (e !== g) begin
      n_errors++;
      $display("wrong value at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task results;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic [2:0] cls(input [1:0] a, input [1:0] b);
    if (a == b)
      cls = a == `TCC_TERM_SINK ? `TCC_CONN_DEBUG : `TCC_CONN_AUDIO;
    else if (a != `TCC_TERM_OPEN && b != `TCC_TERM_OPEN)
      cls = `TCC_CONN_CABLE_SINK;
    else
      cls = (a | b) == `TCC_TERM_SINK ? `TCC_CONN_SINK : `TCC_CONN_CABLE;
  endfunction
  //////////////////////////////////////////////////////////////////////
  // The sense current is random every cycle so the limit flag toggles.
  always @(posedge clk) begin
    #1;
    fvc = 10'($urandom);
  end
  initial begin
    reg [4:0] e;
    wait (rst_n);
    forever begin
      @(conn_state_q);
      #1;
      e = q.size() != 0 ? q.pop_front() : 5'h1f;
      chk(e[4:2], conn_state_q);
      if (e[4:2] == `TCC_CONN_SOURCE)
        chk({1'b0, e[1:0]}, {1'b0, partner_adv_q});
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results;
  end
  initial begin
    void'($urandom(32'h9aaf));
    step(20);
    rst_n = 1;
    step(2);
    // Levels land anywhere inside each class band, edges included.
    for (int v = 0; v < 3; v++)
      for (int a = 0; a < 3; a++)
        for (int b = 0; b < 3; b++)
          if (a != 0 || b != 0) begin
            adv_sel = v;
            cab_lvl = $urandom % cab_t[v];
            sink_lvl = cab_t[v] + $urandom % (det_t[v] - cab_t[v]);
            q.push_back({cls(a, b), 2'h0});
            term_a = a;
            term_b = b;
            step(20);
            tx_req = 1;
            step(2);
            tx_req = 0;
            q.push_back({`TCC_CONN_NONE, 2'h0});
            term_a = 0;
            term_b = 0;
            step(20);
          end
    role_source = 0;
    use_trimmed = 1;
    src_mode = 1;
    for (int k = 0; k < 3; k++) begin
      src_lvl = 10'(k * 'h0c0 + $urandom % 'h0c0);
      step(3);
      q.push_back({`TCC_CONN_SOURCE, 2'(k)});
      src_vbus = 1;
      step(5);
      tx_req = 1;
      step(2);
      tx_req = 0;
      q.push_back({`TCC_CONN_NONE, 2'h0});
      src_vbus = 0;
      step(4);
    end
    // Sink side swap: the source's pull-up collapses while VBUS stays.
    frs_en = 1;
    src_lvl = 10'h0100 + 10'($urandom % 'h80);
    q.push_back({`TCC_CONN_SOURCE, 2'h1});
    src_vbus = 1;
    step(5);
    q.push_back({`TCC_CONN_NONE, 2'h0});
    src_lvl = 10'($urandom % 'h80);
    step(1);
    // The partner now sinks on line a and the core takes the source role.
    q.push_back({`TCC_CONN_SINK, 2'h0});
    src_mode = 0;
    src_vbus = 0;
    role_source = 1;
    term_a = 1;
    step(20);
    // Source side swap requested by the core.
    q.push_back({`TCC_CONN_NONE, 2'h0});
    frs_req = 1;
    step(1);
    frs_req = 0;
    role_source = 0;
    step(20);
    step(5);
    if (q.size() != 0)
      n_errors++;
    results;
  end
endmodule

// *** verilog/tcc_attach_detect.v ***
`include "tcc_consts.vh"

module tcc_attach_detect #(
  parameter AW = 10
) (
  // Clock and reset.
  input wire clk,
  input wire rst_n,
  // Configuration from the core.
  input wire role_source,
  input wire [1:0] adv_sel,
  input wire frs_en,
  input wire frs_req,
  input wire use_trimmed,
  input wire tx_req,
  // Sampled CC line levels and port sensing.
  input wire [AW-1:0] cc_line_a,
  input wire [AW-1:0] cc_line_b,
  input wire vbus_present,
  input wire [AW-1:0] five_volt_current,
  // Analog controls.
  output reg attach_source_current_q,
  output reg trimmed_pulldown_q,
  output reg untrimmed_pulldown_q,
  output reg role_swap_pulldown_a_q,
  output reg role_swap_pulldown_b_q,
  output reg vbus_on_q,
  output reg vconn_a_q,
  output reg vconn_b_q,
  output reg five_volt_current_limit_q,
  output reg tx_oe_a_q,
  output reg tx_oe_b_q,
  // Status to the core.
  output reg [2:0] conn_state_q,
  output reg orient_b_q,
  output reg [1:0] partner_adv_q,
  output reg fast_role_swap_q,
  output reg role_is_source_q,
  output reg watch_a_q,
  output reg watch_b_q,
  output reg [AW-1:0] five_volt_current_q
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_SRC = 4'b0010;
  localparam [3:0] ST_SNK = 4'b0100;
  localparam [3:0] ST_SWAP = 4'b1000;
  // Terminations must hold this long before they are trusted, so that a
  // plug that bounces on insertion cannot switch VBUS on early.
  localparam [7:0] SETTLE = `TCC_SETTLE_CYC;

  reg [3:0] st_q;
  reg [3:0] st_d;
  reg [7:0] cnt_q;
  reg [1:0] ta_q;
  reg [1:0] tb_q;
  reg [AW-1:0] det_th;
  reg [AW-1:0] cab_th;
  reg [1:0] ta;
  reg [1:0] tb;
  reg [2:0] conn_d;
  reg gone;
  reg frs_hit;

  ////////////////////////////////////////////////////////////////////////
  // Per-line classification against the selected thresholds.
  always @* begin
    case (adv_sel)
      `TCC_ADV_1P5: begin
        det_th = `TCC_DET_1P5;
        cab_th = `TCC_CAB_1P5;
      end
      `TCC_ADV_3P0: begin
        det_th = `TCC_DET_3P0;
        cab_th = `TCC_CAB_3P0;
      end
      default: begin
        det_th = `TCC_DET_DEF;
        cab_th = `TCC_CAB_DEF;
      end
    endcase
    // Each line is judged on its own.
    if (cc_line_a < cab_th)
      ta = `TCC_TERM_CABLE;
    else if (cc_line_a < det_th)
      ta = `TCC_TERM_SINK;
    else
      ta = `TCC_TERM_OPEN;
    if (cc_line_b < cab_th)
      tb = `TCC_TERM_CABLE;
    else if (cc_line_b < det_th)
      tb = `TCC_TERM_SINK;
    else
      tb = `TCC_TERM_OPEN;
  end

  ////////////////////////////////////////////////////////////////////////
  // Connection report from the settled pair of terminations.
  always @* begin
    conn_d = `TCC_CONN_NONE;
    if (ta_q == `TCC_TERM_SINK && tb_q == `TCC_TERM_SINK)
      conn_d = `TCC_CONN_DEBUG;
    else if (ta_q == `TCC_TERM_CABLE && tb_q == `TCC_TERM_CABLE)
      conn_d = `TCC_CONN_AUDIO;
    else if (ta_q == `TCC_TERM_SINK || tb_q == `TCC_TERM_SINK) begin
      if (ta_q == `TCC_TERM_CABLE || tb_q == `TCC_TERM_CABLE)
        conn_d = `TCC_CONN_CABLE_SINK;
      else
        conn_d = `TCC_CONN_SINK;
    end else if (ta_q != `TCC_TERM_OPEN || tb_q != `TCC_TERM_OPEN)
      conn_d = `TCC_CONN_CABLE;
    // Disconnect when the watched line rises to or above the detach level.
    gone = (watch_a_q && cc_line_a >= det_th) ||
           (watch_b_q && cc_line_b >= det_th);
  end

  ////////////////////////////////////////////////////////////////////////
  // Swap detection as sink: the source's pull-up collapses under VBUS.
  always @* begin
    frs_hit = frs_en && vbus_present &&
              conn_state_q == `TCC_CONN_SOURCE &&
              (orient_b_q ? cc_line_b : cc_line_a) < `TCC_FRS_TH;
  end

  ////////////////////////////////////////////////////////////////////////
  // Role state machine.
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (role_source)
          st_d = ST_SRC;
        else
          st_d = ST_SNK;
      end
      ST_SRC: begin
        // After a swap the port keeps sourcing until the core takes the role.
        if (!role_source && !fast_role_swap_q)
          st_d = ST_SNK;
        else if (frs_en && frs_req &&
                 conn_state_q == `TCC_CONN_SINK)
          st_d = ST_SWAP;
      end
      ST_SNK: begin
        if (frs_hit)
          st_d = ST_SRC;
        else if (role_source && !fast_role_swap_q)
          st_d = ST_SRC;
      end
      ST_SWAP: begin
        // The swap pulldown stays until the partner drops VBUS.
        if (!vbus_present)
          st_d = ST_SNK;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered state and outputs.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 8'h00;
      ta_q <= `TCC_TERM_OPEN;
      tb_q <= `TCC_TERM_OPEN;
      attach_source_current_q <= 1'b0;
      trimmed_pulldown_q <= 1'b0;
      untrimmed_pulldown_q <= 1'b1;
      role_swap_pulldown_a_q <= 1'b0;
      role_swap_pulldown_b_q <= 1'b0;
      vbus_on_q <= 1'b0;
      vconn_a_q <= 1'b0;
      vconn_b_q <= 1'b0;
      five_volt_current_limit_q <= 1'b0;
      tx_oe_a_q <= 1'b0;
      tx_oe_b_q <= 1'b0;
      conn_state_q <= `TCC_CONN_NONE;
      orient_b_q <= 1'b0;
      partner_adv_q <= `TCC_ADV_DEF;
      fast_role_swap_q <= 1'b0;
      role_is_source_q <= 1'b0;
      watch_a_q <= 1'b0;
      watch_b_q <= 1'b0;
      five_volt_current_q <= {AW{1'b0}};
    end else begin
      st_q <= st_d;
      five_volt_current_q <= five_volt_current;
      five_volt_current_limit_q <= (five_volt_current > `TCC_ILIM);
      // Dead-battery pulldown held until firmware asks for the trim.
      if (use_trimmed)
        untrimmed_pulldown_q <= 1'b0;
      // Only one end talks; driver stays Hi-Z otherwise.
      tx_oe_a_q <= tx_req && conn_state_q != `TCC_CONN_NONE &&
                   !orient_b_q;
      tx_oe_b_q <= tx_req && conn_state_q != `TCC_CONN_NONE &&
                   orient_b_q;
      // The core acknowledges a swap by taking the source role itself.
      if (role_source || (st_d == ST_SNK && st_q == ST_SRC))
        fast_role_swap_q <= 1'b0;
      // A detection in the same cycle wins over the clear.
      if (st_q == ST_SNK && frs_hit)
        fast_role_swap_q <= 1'b1;
      // Swap pulldown on the connected line only.
      role_swap_pulldown_a_q <= (st_d == ST_SWAP) && !orient_b_q;
      role_swap_pulldown_b_q <= (st_d == ST_SWAP) && orient_b_q;
      role_is_source_q <= (st_d == ST_SRC);
      attach_source_current_q <= (st_d == ST_SRC);
      trimmed_pulldown_q <= (st_d != ST_SRC) && !untrimmed_pulldown_q;
      if (st_q == ST_SRC) begin
        // Classifications must hold steady before they are used.
        if (ta == ta_q && tb == tb_q) begin
          if (cnt_q < SETTLE)
            cnt_q <= cnt_q + 8'h01;
        end else
          cnt_q <= 8'h00;
        ta_q <= ta;
        tb_q <= tb;
        if (conn_state_q == `TCC_CONN_SINK ||
            conn_state_q == `TCC_CONN_CABLE_SINK) begin
          if (gone) begin
            conn_state_q <= `TCC_CONN_NONE;
            vbus_on_q <= 1'b0;
            vconn_a_q <= 1'b0;
            vconn_b_q <= 1'b0;
            watch_a_q <= 1'b0;
            watch_b_q <= 1'b0;
            cnt_q <= 8'h00;
          end
        end else if (cnt_q == SETTLE) begin
          conn_state_q <= conn_d;
          vbus_on_q <= (conn_d == `TCC_CONN_SINK) ||
                       (conn_d == `TCC_CONN_CABLE_SINK);
          vconn_a_q <= (conn_d == `TCC_CONN_CABLE_SINK) &&
                       ta_q == `TCC_TERM_CABLE;
          vconn_b_q <= (conn_d == `TCC_CONN_CABLE_SINK) &&
                       tb_q == `TCC_TERM_CABLE;
          // Watch sink line, or both when unattached, cable only or accessory.
          watch_a_q <= ta_q == `TCC_TERM_SINK ||
                       conn_d != `TCC_CONN_SINK &&
                       conn_d != `TCC_CONN_CABLE_SINK;
          watch_b_q <= tb_q == `TCC_TERM_SINK ||
                       conn_d != `TCC_CONN_SINK &&
                       conn_d != `TCC_CONN_CABLE_SINK;
          if (conn_d == `TCC_CONN_SINK || conn_d == `TCC_CONN_CABLE_SINK)
            orient_b_q <= (tb_q == `TCC_TERM_SINK);
        end
      end else if (st_q == ST_SNK) begin
        cnt_q <= 8'h00;
        vbus_on_q <= 1'b0;
        vconn_a_q <= 1'b0;
        vconn_b_q <= 1'b0;
        watch_a_q <= 1'b0;
        watch_b_q <= 1'b0;
        if (vbus_present) begin
          conn_state_q <= `TCC_CONN_SOURCE;
          orient_b_q <= (cc_line_b > cc_line_a);
          if ((cc_line_a > cc_line_b ? cc_line_a : cc_line_b)
              >= `TCC_ADV_SNK_3P0)
            partner_adv_q <= `TCC_ADV_3P0;
          else if ((cc_line_a > cc_line_b ? cc_line_a : cc_line_b)
                   >= `TCC_ADV_SNK_1P5)
            partner_adv_q <= `TCC_ADV_1P5;
          else
            partner_adv_q <= `TCC_ADV_DEF;
        end else
          conn_state_q <= `TCC_CONN_NONE;
        // Leaving the sink role drops the source attach, so a stale
        // report never outlives the role that produced it.
        if (st_d == ST_SRC)
          conn_state_q <= `TCC_CONN_NONE;
      end else if (st_q == ST_SWAP) begin
        // The swap hands the role over: report nothing until resolved.
        conn_state_q <= `TCC_CONN_NONE;
        vbus_on_q <= 1'b0;
        vconn_a_q <= 1'b0;
        vconn_b_q <= 1'b0;
        watch_a_q <= 1'b0;
        watch_b_q <= 1'b0;
      end
    end
  end

endmodule
